/* File: hw/smc_stop_mode_controller.sv */
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`include "smc_defines.svh"

// Behaviour
// - Stop bit halts both oscillators, all activity
// - Stopped: state kept, port drive per enable
// - Stop entry clears prescaler and divider
// - Held PC is stop instruction plus two
// - Resets end stop; warm-up, then single-clock
// - Wake pin, key wakeup, voltage detect release
// - Mode bit: one level, zero edge
// - Level mode: wake pin high releases
// - Level mode: stop refused while pin high
// - Warm-up clock is the entry system clock
// - Pin low during warm-up never restops
// - Edge mode: rising edge releases
// - Edge mode: stop enters with pin high
// - Edge within one machine cycle ignored
// - Warm-up halted; resume with prescaler cleared
// - Key pin at chosen level releases
// - Oscillators restart per mode at entry
module smc_stop_mode_controller
	import smc_pkg::*;
#(
	parameter int NKEY = 4
)(
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [`SMC_AW-1:0] s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [`SMC_AW-1:0] s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               wake_pin,
	input  wire logic [NKEY-1:0]    key_pins,
	input  wire logic               volt_detect,
	input  wire logic               hf_tick,
	input  wire logic               lf_tick,
	input  wire smc_opmode_t        cur_mode,
	input  wire logic [15:0]        cpu_pc,
	output logic                    cpu_halt,
	output logic                    hf_osc_en,
	output logic                    lf_osc_en,
	output logic                    presc_clr,
	output logic                    port_drive_en,
	output logic [15:0]             held_pc,
	output smc_opmode_t             resume_mode
);
	////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second
	logic            pin_m, pin_s, pin_d, vd_m, vd_s;
	logic [NKEY-1:0] key_m, key_s;

	always_ff @(posedge aclk)
	begin
		pin_m <= wake_pin;
		pin_s <= pin_m;
		pin_d <= pin_s;
		vd_m  <= volt_detect;
		vd_s  <= vd_m;
		key_m <= key_pins;
		key_s <= key_m;
	end

	////////////////////////////////////////////////////////////////
	// Register bus
	logic [`SMC_AW-1:0] aw_addr, next_aw_addr;
	logic [7:0]         w_data, next_w_data;
	logic               aw_got, next_aw_got, w_got, next_w_got;
	logic               w_lane, next_w_lane;
	logic               next_bvalid, next_rvalid;
	logic [1:0]         next_bresp, next_rresp;
	logic [31:0]        next_rdata;
	logic               wr_do, wr_hit, stop_wr;
	smc_sysctl_t        sysctl, next_sysctl;
	logic [7:0]         wuctl, next_wuctl, wucnt, next_wucnt;
	logic [7:0]         keycfg, next_keycfg;
	smc_state_t         state, next_state;

	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready  = !w_got && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_do = aw_got && w_got && !s_axi_bvalid;
	assign wr_hit = aw_addr == `SMC_OFS_SYSCTL || aw_addr == `SMC_OFS_WUCTL
		|| aw_addr == `SMC_OFS_WUCNT || aw_addr == `SMC_OFS_KEYCFG
		|| aw_addr == `SMC_OFS_STATUS;
	assign stop_wr = wr_do && w_lane && aw_addr == `SMC_OFS_SYSCTL
		&& w_data[`SMC_BIT_STOP];

	always_comb
	begin
		next_aw_addr = aw_addr;
		next_aw_got  = aw_got;
		next_w_data  = w_data;
		next_w_lane  = w_lane;
		next_w_got   = w_got;
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid && !s_axi_rready;
		next_rresp   = s_axi_rresp;
		next_rdata   = s_axi_rdata;
		next_sysctl  = sysctl;
		next_wuctl   = wuctl;
		next_wucnt   = wucnt;
		next_keycfg  = keycfg;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_addr = s_axi_awaddr;
			next_aw_got  = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_data = s_axi_wdata[7:0];
			next_w_lane = s_axi_wstrb[0];
			next_w_got  = 1'b1;
		end
		if (wr_do)
		begin
			next_aw_got = 1'b0;
			next_w_got  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = wr_hit ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
			if (w_lane)
				unique case (aw_addr)
					`SMC_OFS_SYSCTL:
					begin
						// Mode bit steers release detection
						next_sysctl.release_mode_select =
							w_data[`SMC_BIT_RELEASE_MODE_SELECT];
						next_sysctl.port_output_enable =
							w_data[`SMC_BIT_PORT_OUTPUT_ENABLE];
					end
					`SMC_OFS_WUCTL:  next_wuctl  = w_data;
					`SMC_OFS_WUCNT:  next_wucnt  = w_data;
					`SMC_OFS_KEYCFG: next_keycfg = w_data;
					default:         next_keycfg = keycfg;
				endcase
		end
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `SMC_RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				`SMC_OFS_SYSCTL:
				begin
					next_rdata[`SMC_BIT_STOP]  = state != SMC_RUN;
					next_rdata[`SMC_BIT_RELEASE_MODE_SELECT]  =
						sysctl.release_mode_select;
					next_rdata[`SMC_BIT_PORT_OUTPUT_ENABLE] =
						sysctl.port_output_enable;
				end
				`SMC_OFS_WUCTL:  next_rdata[7:0] = wuctl;
				`SMC_OFS_WUCNT:  next_rdata[7:0] = wucnt;
				`SMC_OFS_KEYCFG: next_rdata[7:0] = keycfg;
				`SMC_OFS_STATUS:
					next_rdata[7:0] = {3'h0, pin_s, vd_s, lf_osc_en,
						state};
				default: next_rresp = `SMC_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_addr      <= '0;
			aw_got       <= 1'b0;
			w_data       <= 8'h00;
			w_lane       <= 1'b0;
			w_got        <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SMC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `SMC_RESP_OKAY;
			s_axi_rdata  <= 32'h0000_0000;
			sysctl       <= '0;
			wuctl        <= 8'h00;
			wucnt        <= `SMC_RST_WUCNT;
			keycfg       <= 8'h00;
		end
		else
		begin
			aw_addr      <= next_aw_addr;
			aw_got       <= next_aw_got;
			w_data       <= next_w_data;
			w_lane       <= next_w_lane;
			w_got        <= next_w_got;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp  <= next_rresp;
			s_axi_rdata  <= next_rdata;
			sysctl       <= next_sysctl;
			wuctl        <= next_wuctl;
			wucnt        <= next_wucnt;
			keycfg       <= next_keycfg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Stop sequencer
	logic [2:0]  blank, next_blank;
	logic [7:0]  wu_cnt, next_wu_cnt;
	logic        src_lf, next_src_lf;
	logic        next_hf, next_lf, next_clr;
	logic [15:0] next_pc;
	smc_opmode_t next_resume;
	logic        key_hit, pin_wake, stop_ok, wu_tick;

	// Key fires when enabled [7:4] and at its chosen level [3:0]
	assign key_hit = |(keycfg[7:4] & ~(key_s ^ keycfg[3:0]));
	assign pin_wake = sysctl.release_mode_select ? pin_s
		: (pin_s && !pin_d);
	// Level mode refuses entry while pin is high; edge mode never does
	assign stop_ok = !(sysctl.release_mode_select && pin_s);
	assign wu_tick = src_lf ? lf_tick : hf_tick;

	always_comb
	begin
		next_state  = state;
		next_blank  = blank;
		next_wu_cnt = wu_cnt;
		next_src_lf = src_lf;
		next_hf     = hf_osc_en;
		next_lf     = lf_osc_en;
		next_clr    = 1'b0;
		next_pc     = held_pc;
		next_resume = resume_mode;
		unique case (state)
			SMC_RUN:
				if (stop_wr && stop_ok)
				begin
					next_state  = SMC_STOP;
					next_hf     = 1'b0;
					next_lf     = 1'b0;
					next_clr    = 1'b1;
					next_pc     = cpu_pc + 16'h0002;
					next_resume = cur_mode;
					next_src_lf = cur_mode == SMC_SLOW_LOW_FREQ_MODE;
					next_blank  = 3'(`SMC_MCYC_CLKS + `SMC_SYNC_CLKS);
				end
			SMC_STOP:
			begin
				if (blank != 3'h0)
					next_blank = blank - 3'h1;
				// Wakes inside the first machine cycle are dropped
				else if (pin_wake || key_hit || vd_s)
				begin
					next_state  = SMC_WARM;
					next_wu_cnt = 8'h00;
					next_hf = resume_mode != SMC_SLOW_LOW_FREQ_MODE;
					next_lf = resume_mode != SMC_NORMAL_SINGLE_CLOCK_MODE;
				end
			end
			SMC_WARM:
				// No path back to stop from here
				if (wu_tick)
				begin
					if (wu_cnt >= wucnt)
					begin
						next_state = SMC_RUN;
						next_clr   = 1'b1;
					end
					else
						next_wu_cnt = wu_cnt + 8'h01;
				end
			default: next_state = SMC_RUN;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			// Reset ends stop and warms up into single-clock
			state       <= SMC_WARM;
			blank       <= 3'h0;
			wu_cnt      <= 8'h00;
			src_lf      <= 1'b0;
			hf_osc_en   <= 1'b1;
			lf_osc_en   <= 1'b0;
			presc_clr   <= 1'b0;
			held_pc     <= 16'h0000;
			resume_mode <= SMC_NORMAL_SINGLE_CLOCK_MODE;
		end
		else
		begin
			state       <= next_state;
			blank       <= next_blank;
			wu_cnt      <= next_wu_cnt;
			src_lf      <= next_src_lf;
			hf_osc_en   <= next_hf;
			lf_osc_en   <= next_lf;
			presc_clr   <= next_clr;
			held_pc     <= next_pc;
			resume_mode <= next_resume;
		end
	end

	// CPU stays frozen through stop and warm-up
	assign cpu_halt = state != SMC_RUN;
	// Latches keep driving only when enabled while stopped
	assign port_drive_en = state == SMC_RUN || sysctl.port_output_enable;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_stop_entry: assert property (state == SMC_RUN && stop_wr && stop_ok
		|=> state == SMC_STOP && !hf_osc_en && !lf_osc_en && presc_clr)
		else $error("stop entry wrong");
	a_level_refuse: assert property (state == SMC_RUN && stop_wr
		&& sysctl.release_mode_select && pin_s |=> state == SMC_RUN)
		else $error("level stop not refused");
	a_edge_enter: assert property (state == SMC_RUN && stop_wr
		&& !sysctl.release_mode_select |=> state == SMC_STOP)
		else $error("edge stop not entered");
	a_blank_hold: assert property (state == SMC_STOP
		&& blank != 3'h0 |=> state == SMC_STOP)
		else $error("woke in blank");
	a_level_wake: assert property (state == SMC_STOP && blank == 3'h0
		&& sysctl.release_mode_select && pin_s |=> state == SMC_WARM)
		else $error("level wake missed");
	a_warm_stay: assert property (state == SMC_WARM
		|=> state != SMC_STOP)
		else $error("restopped in warm-up");
	a_warm_done: assert property (state == SMC_WARM && wu_tick
		&& wu_cnt >= wucnt |=> state == SMC_RUN && presc_clr)
		else $error("warm-up end wrong");
	a_pc_held: assert property (state != SMC_RUN ##1 state != SMC_RUN
		|-> $stable(held_pc))
		else $error("held pc changed");
	a_slow_osc: assert property (state == SMC_WARM
		&& resume_mode == SMC_SLOW_LOW_FREQ_MODE |-> !hf_osc_en && lf_osc_en)
		else $error("osc restart wrong");

	c_level_cycle: cover property (state == SMC_STOP
		&& sysctl.release_mode_select ##1 state == SMC_WARM);
	c_edge_cycle: cover property (state == SMC_STOP
		&& !sysctl.release_mode_select ##1 state == SMC_WARM);
	c_key_wake: cover property (state == SMC_STOP && key_hit
		&& blank == 3'h0);
	c_resume: cover property (state == SMC_WARM ##1 state == SMC_RUN);
endmodule

/* File: hw/smc_defines.svh */
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_AW          8
`define SMC_OFS_SYSCTL  8'h00
`define SMC_OFS_WUCTL   8'h04
`define SMC_OFS_WUCNT   8'h08
`define SMC_OFS_KEYCFG  8'h0C
`define SMC_OFS_STATUS  8'h10
`define SMC_BIT_STOP    7
`define SMC_BIT_RELEASE_MODE_SELECT    6
`define SMC_BIT_PORT_OUTPUT_ENABLE   4
`define SMC_RST_WUCNT   8'hFF
`define SMC_MCYC_CLKS   4
// Blank also spans the pin synchroniser, so the window is timed at the pin
`define SMC_SYNC_CLKS   2
`define SMC_RESP_OKAY   2'h0
`define SMC_RESP_SLVERR 2'h2
`endif

/* File: hw/smc_pkg.sv */
package smc_pkg;
	typedef enum logic [1:0] {
		SMC_RUN,
		SMC_STOP,
		SMC_WARM
	} smc_state_t;
	typedef enum logic [1:0] {
		SMC_NORMAL_SINGLE_CLOCK_MODE,
		SMC_NORMAL_DUAL_CLOCK_MODE,
		SMC_SLOW_LOW_FREQ_MODE
	} smc_opmode_t;
	typedef struct packed {
		logic release_mode_select;
		logic port_output_enable;
	} smc_sysctl_t;
endpackage

/* File: testbench/smc_wake_src.sv */
// Outside circuit driving the wake pin; it may lag the request
module smc_wake_src (
	input  wire logic       aclk,
	input  wire logic       level,
	input  wire logic [3:0] lag,
	output logic            wake_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	initial
	begin
		wake_pin = 1'b0;
		cnt = 4'h0;
	end
	// A slow source settles only after lag+1 clocks
	always @(posedge aclk)
	begin
		if (level === wake_pin)
			cnt <= 4'h0;
		else if (cnt >= lag)
		begin
			wake_pin <= level;
			cnt <= 4'h0;
		end
		else
			cnt <= cnt + 4'h1;
	end
endmodule

/* File: testbench/smc_stop_mode_controller_tb_top.sv */
module smc_stop_mode_controller_tb_top import smc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, wake_pin;
	logic        volt_detect, hf_tick, lf_tick, cpu_halt, hf_osc_en;
	logic        lf_osc_en, presc_clr, port_drive_en, wake_lvl, pclr_q;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
	logic [3:0]  s_axi_wstrb, key_pins, lag, lf_cnt;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rresp_q, bresp_q;
	logic [15:0] cpu_pc, held_pc;
	smc_opmode_t cur_mode, resume_mode;
	int          failures, n_checks;
	////////////////////////////////////////////////////////////////////////
	smc_stop_mode_controller u_dut (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.wake_pin, .key_pins, .volt_detect, .hf_tick, .lf_tick, .cur_mode,
		.cpu_pc, .cpu_halt, .hf_osc_en, .lf_osc_en, .presc_clr,
		.port_drive_en, .held_pc, .resume_mode);
	smc_wake_src u_src (.aclk, .level(wake_lvl), .lag, .wake_pin);
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Slow oscillator ticks once every four clocks
	always @(posedge aclk)
	begin
		lf_cnt <= lf_cnt + 4'h1;
		lf_tick <= (lf_cnt[1:0] == 2'h3);
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Valid drops only once ready was seen, so a following write never clashes with this one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		pclr_q = presc_clr;
		bresp_q = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd_q = s_axi_rdata;
		rresp_q = s_axi_rresp;
	endtask
	task automatic wt(input logic v, input int n);
		for (int i = 0; i < n && cpu_halt !== v; i++)
			@(posedge aclk);
		chk(cpu_halt, v);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_edge;
		wake_lvl <= 1'b1;
		step(5);
		cpu_pc <= 16'h1234;
		// Bench CPU raises no interrupts, so stop is always entered masked
		wr(8'h00, 8'h80);
		chk(pclr_q, 1'b1);
		chk({cpu_halt, hf_osc_en, lf_osc_en}, 3'b100);
		chk(held_pc, 16'h1236);
		chk(port_drive_en, 1'b0);
		rd(8'h00);
		chk(rd_q[7], 1'b1);
		step(20);
		chk(cpu_halt, 1'b1);
		wake_lvl <= 1'b0;
		step(5);
		lag <= 4'h3;
		wake_lvl <= 1'b1;
		wt(1'b0, 40);
		chk(presc_clr, 1'b1);
		lag <= 4'h0;
	endtask
	task automatic t_level;
		wr(8'h08, 8'h10);
		wr(8'h00, 8'h40);
		wr(8'h00, 8'hC0);
		step(3);
		chk(cpu_halt, 1'b0);
		wake_lvl <= 1'b0;
		step(5);
		rd(8'h10);
		chk(rd_q[4], 1'b0);
		wr(8'h00, 8'hD0);
		chk(port_drive_en, 1'b1);
		step(8);
		wake_lvl <= 1'b1;
		step(6);
		wake_lvl <= 1'b0;
		wt(1'b0, 60);
		step(10);
		chk(cpu_halt, 1'b0);
	endtask
	// Pin rises while stop is still settling; edge mode drops that edge, so only voltage detect releases the stop
	task automatic t_blank;
		cur_mode <= SMC_NORMAL_DUAL_CLOCK_MODE;
		wr(8'h00, 8'h80);
		wake_lvl <= 1'b1;
		step(20);
		chk(cpu_halt, 1'b1);
		volt_detect <= 1'b1;
		wt(1'b0, 60);
		chk({hf_osc_en, lf_osc_en}, 2'b11);
		volt_detect <= 1'b0;
		wake_lvl <= 1'b0;
	endtask
	task automatic t_key;
		cur_mode <= SMC_SLOW_LOW_FREQ_MODE;
		wr(8'h0C, 8'h11);
		chk(bresp_q, 2'h0);
		wr(8'h00, 8'h80);
		step(8);
		key_pins <= 4'h1;
		step(25);
		chk({cpu_halt, hf_osc_en, lf_osc_en}, 3'b101);
		wt(1'b0, 100);
		chk(resume_mode, SMC_SLOW_LOW_FREQ_MODE);
		key_pins <= 4'h0;
	endtask
	task automatic t_rst;
		wr(8'h00, 8'h80);
		step(3);
		aresetn <= 1'b0;
		step(2);
		aresetn <= 1'b1;
		step(1);
		chk({cpu_halt, hf_osc_en, lf_osc_en}, 3'b110);
		chk(resume_mode, SMC_NORMAL_SINGLE_CLOCK_MODE);
		rd(8'h08);
		chk(rd_q, 32'h0000_00FF);
		rd(8'h40);
		chk(rresp_q, 2'h2);
		wr(8'h40, 8'h00);
		chk(bresp_q, 2'h2);
		wt(1'b0, 300);
	endtask
	task automatic summarize;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_bready, s_axi_rready, hf_tick} = 3'h7;
		{volt_detect, wake_lvl, lf_tick, key_pins, lag, lf_cnt} = 15'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		cur_mode = SMC_NORMAL_SINGLE_CLOCK_MODE;
		cpu_pc = 16'h0000;
		step(10);
		aresetn <= 1'b1;
		wt(1'b0, 300);
		wr(8'h08, 8'h03);
		t_edge();
		t_level();
		t_blank();
		t_key();
		t_rst();
		summarize();
	end
	// Whole run needs about a thousand clocks
	initial
	begin
		#100000;
		failures++;
		summarize();
	end
endmodule
